// ==== shared/sadc_pkg.sv ====
// package: register map, field layout and timing constants of the converter control
package sadc_pkg;
  // register byte addresses on the wishbone bus
  localparam logic [4:0] ADDR_CONTROL_MAIN = 5'h00;
  localparam logic [4:0] ADDR_PORT_CONFIG  = 5'h04;
  localparam logic [4:0] ADDR_TIMING_CFG   = 5'h08;
  localparam logic [4:0] ADDR_RESULT_HIGH  = 5'h0c;
  localparam logic [4:0] ADDR_RESULT_LOW   = 5'h10;
  localparam logic [4:0] ADDR_IRQ_STATUS   = 5'h14;
  localparam logic [4:0] ADDR_IRQ_CLEAR    = 5'h18;
  localparam logic [4:0] ADDR_IRQ_ENABLE   = 5'h1c;
  // control main fields
  localparam int BIT_ON   = 0;
  localparam int BIT_GO   = 1;
  localparam int CHS_LO   = 2;
  localparam int CHS_HI   = 5;
  // port config fields
  localparam int BIT_VREF_EXT = 7;
  // timing config fields
  localparam int BIT_RIGHT_JUST = 7;
  localparam int BIT_RC_CLOCK   = 6;
  localparam int ACQ_LO         = 3;
  localparam int ACQ_HI         = 5;
  localparam int DIV_LO         = 0;
  localparam int DIV_HI         = 2;
  // channel coding
  localparam logic [3:0] CHAN_LAST  = 4'hc;
  localparam logic [3:0] CHAN_GAP_LO = 4'h5;
  localparam logic [3:0] CHAN_GAP_HI = 4'h7;
  // conversion shape
  localparam int RES_BITS      = 12;
  localparam int CONV_STEPS    = 13;
  localparam int PINS_LARGE    = 13;
  localparam int PINS_SMALL    = 10;
  // internal rc clock step: nominal 1 us at 100 MHz
  localparam int RC_PERIOD_NS  = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RC_CYCLES     = RC_PERIOD_NS / CLK_PERIOD_NS;
  // states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACQ  = 4'b0010,
    ST_CONV = 4'b0100,
    ST_DONE = 4'b1000
  } sadc_state_type;
  // comparator request carrier: trial, channel and reference select
  typedef struct packed {
    logic [RES_BITS-1:0] trial;
    logic [3:0]          channel;
    logic                ref_ext;
  } sadc_cmp_type;
endpackage

// ==== src/sadc_core.sv ====
// sar converter control: registers, sequencer, pin configuration and interrupt
//
// Functional notes
// RL1: thirteen analog inputs on the large variant, ten on the small one.
// RL2: every conversion yields a twelve-bit unsigned value.
// RL3: channel select is control bits 5..2; codes 0..12 pick channels 0..12.
// RL4: small variant leaves channel codes five to seven unimplemented.
// RL5: unimplemented code converts a floating input, no error raised.
// RL6: status bit 1 reads one while converting, zero when idle.
// RL7: control bit 0 switches the converter on or off.
// RL8: control bits 7 and 6 always read zero.
// RL9: reset restores registers, turns module off, aborts any conversion.
// RL10: software picks supply rails or external reference pins.
// RL11: software uses the rc clock when converting through sleep.
// RL12: successive approximation resolves one bit per conversion clock step.
// RL13: on completion load result pair, clear status bit, set done flag.
// RL14: each converter pin is analog input or digital pin by software; here pin 0 stays analog at every low config nibble value.
// RL15: timing register picks clock source, acquisition time and justification.
// RL16: conversion without acquisition takes 13 to 14 conversion clocks.
// RL17: result readable on the cycle right after completion.
// RL18: converter returns from convert to sample on the next clock.
// RL19: software starts a conversion by setting the status bit while on.
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module sadc_core #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int NUM_PINS      = sadc_pkg::PINS_LARGE
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [4:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  // analog front end
  output sadc_pkg::sadc_cmp_type    cmp_req_o,
  output logic                      sample_o,
  input  wire logic                 cmp_high_i,
  output logic      [NUM_PINS-1:0]  pin_analog_o,
  // interrupt
  output logic                      irq_o
);
  // ************************************************
  // registers and state
  // ************************************************
  logic                            conv_on;
  logic [3:0]                      channel_select;
  logic [7:0]                      port_cfg;
  logic [7:0]                      timing_cfg;
  logic [sadc_pkg::RES_BITS-1:0]   result;
  logic [sadc_pkg::RES_BITS-1:0]   trial;
  logic [3:0]                      bit_idx;
  logic [8:0]                      step_cnt;
  logic [3:0]                      conv_ticks;
  logic [4:0]                      acq_cnt;
  logic                            step_tick;
  logic                            done_flag;
  logic                            done_en;
  logic                            done_pulse;
  logic                            cmp_sync1;
  logic                            cmp_sync2;
  logic                            req_hit;
  logic                            wr_ctl;
  logic                            go_req;
  sadc_pkg::sadc_state_type        state;
  logic [8:0]                      step_div;
  logic [4:0]                      acq_len;

  assign req_hit = cyc_i && stb_i && !ack_o;
  assign wr_ctl  = req_hit && we_i && sel_i[0] && adr_i == sadc_pkg::ADDR_CONTROL_MAIN;
  assign go_req  = wr_ctl && dat_i[sadc_pkg::BIT_GO] && dat_i[sadc_pkg::BIT_ON]; // RL19

  // conversion clock step length: rc clock or divided system clock
  always_comb begin
    if (timing_cfg[sadc_pkg::BIT_RC_CLOCK]) begin
      step_div = 9'(sadc_pkg::RC_CYCLES); // RL15
    end else begin
      step_div = 9'(2) << timing_cfg[sadc_pkg::DIV_HI:sadc_pkg::DIV_LO];
    end
  end

  // acquisition length in conversion clocks, zero code means one step
  always_comb begin
    acq_len = {1'b0, timing_cfg[sadc_pkg::ACQ_HI:sadc_pkg::ACQ_LO], 1'b0}; // RL15
    if (acq_len == 5'h00) begin
      acq_len = 5'h01;
    end
  end

  // ************************************************
  // comparator input synchroniser
  // ************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_sync1 <= 1'b0;
      cmp_sync2 <= 1'b0;
    end else begin
      cmp_sync1 <= cmp_high_i;
      cmp_sync2 <= cmp_sync1;
    end
  end

  // conversion clock divider, enable pulse per step
  // steps shorter than four clocks outrun the comparator path, so keep div at one or more
  always_ff @(posedge clk_i) begin
    if (rst_i || state == sadc_pkg::ST_IDLE) begin
      step_cnt  <= 9'h000;
      step_tick <= 1'b0;
    end else if (step_cnt + 9'h001 >= step_div) begin
      step_cnt  <= 9'h000;
      step_tick <= 1'b1;
    end else begin
      step_cnt  <= step_cnt + 9'h001;
      step_tick <= 1'b0;
    end
  end

  // ************************************************
  // sequencer
  // ************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= sadc_pkg::ST_IDLE; // RL9
      trial      <= '0;
      bit_idx    <= 4'h0;
      acq_cnt    <= 5'h00;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      unique case (state)
        sadc_pkg::ST_IDLE: begin
          if (go_req && conv_on) begin
            state   <= sadc_pkg::ST_ACQ; // RL19
            acq_cnt <= 5'h00;
          end
        end
        sadc_pkg::ST_ACQ: begin
          if (!conv_on) begin
            state <= sadc_pkg::ST_IDLE;
          end else if (step_tick) begin
            if (acq_cnt + 5'h01 >= acq_len) begin
              state   <= sadc_pkg::ST_CONV;
              bit_idx <= 4'(sadc_pkg::RES_BITS); // one settling step before the msb trial
              trial   <= '0;
            end else begin
              acq_cnt <= acq_cnt + 5'h01;
            end
          end
        end
        sadc_pkg::ST_CONV: begin
          if (!conv_on) begin
            state <= sadc_pkg::ST_IDLE; // RL7
          end else if (step_tick) begin
            // the settling step decides nothing; later steps keep or drop the trial bit
            if (bit_idx != 4'(sadc_pkg::RES_BITS) && !cmp_sync2) begin
              trial[bit_idx] <= 1'b0; // RL12
            end
            if (bit_idx == 4'h0) begin
              state <= sadc_pkg::ST_DONE; // RL16
            end else begin
              bit_idx            <= bit_idx - 4'h1;
              trial[bit_idx-4'h1] <= 1'b1;
            end
          end
        end
        sadc_pkg::ST_DONE: begin
          state      <= sadc_pkg::ST_IDLE; // RL18
          done_pulse <= 1'b1;
        end
        default: state <= sadc_pkg::ST_IDLE;
      endcase
    end
  end

  // result pair loads as the sequence completes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result <= '0;
    end else if (state == sadc_pkg::ST_DONE) begin
      result <= trial; // RL13 RL17 RL2 RL5
    end
  end

  // conversion clock steps spent in the convert phase
  always_ff @(posedge clk_i) begin
    if (rst_i || state != sadc_pkg::ST_CONV) begin
      conv_ticks <= 4'h0;
    end else if (step_tick) begin
      conv_ticks <= conv_ticks + 4'h1; // RL16
    end
  end

  // ************************************************
  // software registers
  // ************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_on        <= 1'b0; // RL9
      channel_select <= 4'h0;
      port_cfg       <= 8'h00;
      timing_cfg     <= 8'h00;
      done_en        <= 1'b0;
    end else if (req_hit && we_i && sel_i[0]) begin
      unique case (adr_i)
        sadc_pkg::ADDR_CONTROL_MAIN: begin
          conv_on        <= dat_i[sadc_pkg::BIT_ON]; // RL7
          channel_select <= dat_i[sadc_pkg::CHS_HI:sadc_pkg::CHS_LO]; // RL3
        end
        sadc_pkg::ADDR_PORT_CONFIG: port_cfg   <= dat_i[7:0]; // RL14 RL10
        sadc_pkg::ADDR_TIMING_CFG:  timing_cfg <= dat_i[7:0]; // RL15
        sadc_pkg::ADDR_IRQ_ENABLE:  done_en    <= dat_i[0];
        default: ;
      endcase
    end
  end

  // sticky done flag; a new completion wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_flag <= 1'b0;
    end else if (done_pulse) begin
      done_flag <= 1'b1; // RL13
    end else if (req_hit && we_i && sel_i[0] && adr_i == sadc_pkg::ADDR_IRQ_CLEAR
                 && dat_i[0]) begin
      done_flag <= 1'b0;
    end
  end

  // read mux and single-cycle ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req_hit;
      dat_o <= 32'h0000_0000;
      if (req_hit && !we_i) begin
        unique case (adr_i)
          sadc_pkg::ADDR_CONTROL_MAIN: dat_o[7:0] <= {2'b00, channel_select, // RL8
              conv_on && state != sadc_pkg::ST_IDLE, conv_on}; // RL6
          sadc_pkg::ADDR_PORT_CONFIG:  dat_o[7:0] <= port_cfg;
          sadc_pkg::ADDR_TIMING_CFG:   dat_o[7:0] <= timing_cfg;
          sadc_pkg::ADDR_RESULT_HIGH:  dat_o[7:0] <= timing_cfg[sadc_pkg::BIT_RIGHT_JUST]
              ? {4'h0, result[11:8]} : result[11:4];
          sadc_pkg::ADDR_RESULT_LOW:   dat_o[7:0] <= timing_cfg[sadc_pkg::BIT_RIGHT_JUST]
              ? result[7:0] : {result[3:0], 4'h0};
          sadc_pkg::ADDR_IRQ_STATUS:   dat_o[0] <= done_flag;
          sadc_pkg::ADDR_IRQ_ENABLE:   dat_o[0] <= done_en;
          default: ;
        endcase
      end
    end
  end

  // interrupt output level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (done_flag || done_pulse) && done_en;
    end
  end

  // ************************************************
  // analog side drive
  // ************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_req_o <= '0;
      sample_o  <= 1'b1;
    end else begin
      cmp_req_o.trial   <= trial; // RL12
      cmp_req_o.channel <= channel_select; // RL3 RL5
      cmp_req_o.ref_ext <= port_cfg[sadc_pkg::BIT_VREF_EXT]; // RL10
      sample_o          <= state != sadc_pkg::ST_CONV; // RL18
    end
  end

  // per-pin analog mode: pins numbered up to the low config nibble value stay analog
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      localparam bit PIN_EXISTS = LARGE_VARIANT ||
          !(4'(gi) >= sadc_pkg::CHAN_GAP_LO && 4'(gi) <= sadc_pkg::CHAN_GAP_HI); // RL1 RL4
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_analog_o[gi] <= PIN_EXISTS;
        end else begin
          pin_analog_o[gi] <= PIN_EXISTS && (4'(gi) <= port_cfg[3:0]); // RL14
        end
      end
    end
  endgenerate

  // ************************************************
  // checks
  // ************************************************
  AST_DONE_SETS_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
    done_pulse |=> done_flag) else $error("done flag not set after completion");
  AST_RESULT_NEXT: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
    state == sadc_pkg::ST_DONE |=> result == $past(trial)) else $error("result not loaded");
  AST_BACK_TO_SAMPLE: assert property (@(posedge clk_i) disable iff (rst_i) // RL18
    state == sadc_pkg::ST_DONE |=> state == sadc_pkg::ST_IDLE) else $error("no return");
  AST_OFF_ABORTS: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
    !conv_on && state == sadc_pkg::ST_CONV |=> state == sadc_pkg::ST_IDLE)
    else $error("conversion survived disable");
  AST_START: assert property (@(posedge clk_i) disable iff (rst_i) // RL19
    state == sadc_pkg::ST_IDLE && go_req && conv_on |=> state == sadc_pkg::ST_ACQ)
    else $error("start ignored");
  AST_CONV_FIRST: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
    $rose(state == sadc_pkg::ST_CONV) |-> bit_idx == 4'(sadc_pkg::RES_BITS))
    else $error("bad first step");
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held");
  AST_RESET_OFF: assert property (@(posedge clk_i) // RL9
    rst_i |=> !conv_on && state == sadc_pkg::ST_IDLE) else $error("reset left module on");
  AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    done_flag && done_en |=> irq_o) else $error("irq missing");

  // sequencer timing, analog side, interrupt and bus checks
  AST_CONV_LEN: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
    state == sadc_pkg::ST_DONE |-> conv_ticks == 4'(sadc_pkg::CONV_STEPS))
    else $error("conversion step count wrong");
  AST_SAMPLE_CONV: assert property (@(posedge clk_i) disable iff (rst_i) // RL18
    state == sadc_pkg::ST_CONV |=> !sample_o) else $error("sampling during conversion");
  AST_SAMPLE_AGAIN: assert property (@(posedge clk_i) disable iff (rst_i) // RL18
    state == sadc_pkg::ST_DONE |=> sample_o) else $error("no return to sample");
  AST_ACQ_ABORT: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
    !conv_on && state == sadc_pkg::ST_ACQ |=> state == sadc_pkg::ST_IDLE)
    else $error("acquisition survived disable");
  AST_RESULT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
    state != sadc_pkg::ST_DONE |=> $stable(result)) else $error("result changed early");
  AST_IRQ_MASKED: assert property (@(posedge clk_i) disable iff (rst_i)
    !done_en |=> !irq_o) else $error("masked irq raised");
  AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
    req_hit |=> ack_o) else $error("ack missing");
  AST_FLAG_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
    req_hit && we_i && sel_i[0] && adr_i == sadc_pkg::ADDR_IRQ_CLEAR && dat_i[0]
    && !done_pulse |=> !done_flag) else $error("done flag not cleared");
endmodule
`default_nettype wire

// ==== tb/sadc_analog_model.sv ====
// analog front end model: channel levels seen by the comparator
`timescale 1ns/1ps
`default_nettype none
module sadc_analog_model (
  // clock
  input  wire logic                   clk_i,
  // converter side
  input  wire sadc_pkg::sadc_cmp_type cmp_req_i,
  output logic                        cmp_high_o
);
  logic [11:0] float_q = 12'h000; // floating input drifts every cycle
  logic [11:0] level;
  // channel level, halved against the external references
  always_comb begin
    if (cmp_req_i.channel > sadc_pkg::CHAN_LAST) begin
      level = float_q;
    end else begin
      level = 12'h0a5 + 12'(cmp_req_i.channel) * 12'h13b;
      if (cmp_req_i.ref_ext) begin
        level = level >> 1;
      end
    end
  end
  // floating input drifts every cycle
  always_ff @(posedge clk_i) begin
    float_q <= float_q + 12'h3d7;
  end
  // comparator answers at once, like the analog part: input at or above trial
  assign cmp_high_o = level >= cmp_req_i.trial;
endmodule
`default_nettype wire

// ==== tb/sadc_core_tb.sv ====
// testbench: register access, conversions, interrupt and abort
`timescale 1ns/1ps
`default_nettype none
module sadc_core_tb;
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   cyc_i = 1'b0;
  logic                   stb_i = 1'b0;
  logic                   we_i  = 1'b0;
  logic [4:0]             adr_i = 5'h00;
  logic [3:0]             sel_i = 4'h0;
  logic [31:0]            dat_i = 32'h0;
  logic [31:0]            dat_o;
  logic                   ack_o;
  sadc_pkg::sadc_cmp_type cmp_req;
  logic                   sample_o;
  logic                   cmp_high;
  logic [12:0]            pin_analog_o;
  logic                   irq_o;
  logic [31:0]            rd;
  int                     n_errors = 0;
  int                     tests_run = 0;

  // clock of 100 MHz
  always #5 clk_i = ~clk_i;

  sadc_core i_sadc_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .cmp_req_o(cmp_req), .sample_o(sample_o), .cmp_high_i(cmp_high),
    .pin_analog_o(pin_analog_o), .irq_o(irq_o));
  sadc_analog_model i_sadc_analog_model (.clk_i(clk_i), .cmp_req_i(cmp_req),
    .cmp_high_o(cmp_high));

  // verdict and end of run
  task automatic complete_run();
    $display("compares %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // compare one value
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one classic wishbone cycle, read data lands in rd
  task automatic wb(input logic wr, input logic [4:0] adr, input logic [31:0] dat);
    int i;
    i = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= adr;
    sel_i <= 4'h1;
    dat_i <= dat;
    do begin
      @(posedge clk_i);
      i++;
      if (i > 50) begin
        n_errors++;
        $display("MISMATCH at %0t: no bus answer", $time);
        complete_run();
      end
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // expected level of a channel
  function automatic logic [11:0] level(input logic [3:0] ch, input logic ext);
    level = 12'h0a5 + 12'(ch) * 12'h13b;
    if (ext) begin
      level = level >> 1;
    end
  endfunction

  // start a conversion and poll the busy bit until idle
  task automatic convert(input logic [3:0] ch);
    int i;
    i = 0;
    wb(1'b1, sadc_pkg::ADDR_CONTROL_MAIN, {26'h0, ch, 2'b01});
    wb(1'b1, sadc_pkg::ADDR_CONTROL_MAIN, {26'h0, ch, 2'b11});
    wb(1'b0, sadc_pkg::ADDR_CONTROL_MAIN, 32'h0);
    check(rd & 32'h2, 32'h2);
    while (rd[1] === 1'b1) begin
      wb(1'b0, sadc_pkg::ADDR_CONTROL_MAIN, 32'h0);
      i++;
      if (i > 1000) begin
        n_errors++;
        $display("MISMATCH at %0t: conversion hangs", $time);
        complete_run();
      end
    end
  endtask

  // read the result pair in the chosen justification
  task automatic check_result(input logic [11:0] exp, input logic right);
    logic [31:0] hi;
    wb(1'b0, sadc_pkg::ADDR_RESULT_HIGH, 32'h0);
    hi = rd;
    wb(1'b0, sadc_pkg::ADDR_RESULT_LOW, 32'h0);
    if (right) begin
      check(hi, {28'h0, exp[11:8]});
      check(rd, {24'h0, exp[7:0]});
    end else begin
      check(hi, {24'h0, exp[11:4]});
      check(rd, {24'h0, exp[3:0], 4'h0});
    end
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    check({19'h0, pin_analog_o}, 32'h1fff);
    check({31'h0, sample_o}, 32'h1);
    check({30'h0, irq_o, ack_o}, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, sadc_pkg::ADDR_CONTROL_MAIN, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, sadc_pkg::ADDR_CONTROL_MAIN, 32'hfc);
    wb(1'b0, sadc_pkg::ADDR_CONTROL_MAIN, 32'h0);
    check(rd, 32'h3c);
    wb(1'b0, 5'h02, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, sadc_pkg::ADDR_PORT_CONFIG, 32'h04);
    check({19'h0, pin_analog_o}, 32'h1f);
    wb(1'b1, sadc_pkg::ADDR_IRQ_ENABLE, 32'h1);
    wb(1'b1, sadc_pkg::ADDR_TIMING_CFG, 32'h81);
    for (int k = 0; k < 13; k += 4) begin
      convert(4'(k));
      check_result(level(4'(k), 1'b0), 1'b1);
      check({30'h0, irq_o, sample_o}, 32'h3);
      wb(1'b0, sadc_pkg::ADDR_IRQ_STATUS, 32'h0);
      check(rd, 32'h1);
      wb(1'b1, sadc_pkg::ADDR_IRQ_CLEAR, 32'h1);
      check({31'h0, irq_o}, 32'h0);
    end
    // external references, left justified, interrupt masked
    wb(1'b1, sadc_pkg::ADDR_TIMING_CFG, 32'h01);
    wb(1'b1, sadc_pkg::ADDR_PORT_CONFIG, 32'h8c);
    wb(1'b1, sadc_pkg::ADDR_IRQ_ENABLE, 32'h0);
    convert(4'h3);
    check_result(level(4'h3, 1'b1), 1'b0);
    check({31'h0, irq_o}, 32'h0);
    // floating channel still completes
    wb(1'b1, sadc_pkg::ADDR_IRQ_CLEAR, 32'h1);
    wb(1'b1, sadc_pkg::ADDR_PORT_CONFIG, 32'h0c);
    convert(4'hd);
    wb(1'b0, sadc_pkg::ADDR_IRQ_STATUS, 32'h0);
    check(rd, 32'h1);
    // rc conversion clock
    wb(1'b1, sadc_pkg::ADDR_TIMING_CFG, 32'hc1);
    convert(4'h2);
    check_result(level(4'h2, 1'b0), 1'b1);
    // switching off aborts
    wb(1'b1, sadc_pkg::ADDR_TIMING_CFG, 32'h81);
    wb(1'b1, sadc_pkg::ADDR_IRQ_CLEAR, 32'h1);
    wb(1'b1, sadc_pkg::ADDR_CONTROL_MAIN, 32'h0b);
    repeat (20) @(posedge clk_i);
    wb(1'b0, sadc_pkg::ADDR_CONTROL_MAIN, 32'h0);
    check(rd, 32'h0b);
    wb(1'b1, sadc_pkg::ADDR_CONTROL_MAIN, 32'h08);
    repeat (100) @(posedge clk_i);
    wb(1'b0, sadc_pkg::ADDR_CONTROL_MAIN, 32'h0);
    check(rd, 32'h08);
    wb(1'b0, sadc_pkg::ADDR_IRQ_STATUS, 32'h0);
    check(rd, 32'h0);
    // reset in mid conversion
    wb(1'b1, sadc_pkg::ADDR_CONTROL_MAIN, 32'h09);
    wb(1'b1, sadc_pkg::ADDR_CONTROL_MAIN, 32'h0b);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check({19'h0, pin_analog_o}, 32'h1fff);
    check({31'h0, sample_o}, 32'h1);
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (100) @(posedge clk_i);
    wb(1'b0, sadc_pkg::ADDR_CONTROL_MAIN, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, sadc_pkg::ADDR_IRQ_STATUS, 32'h0);
    check(rd, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
